// *** hwwd_consts.vh ***
// Constants for the hardware watchdog: register map, fields, timing.
// Assumes a 32-bit APB with word-aligned registers, index times four.
`ifndef HWWD_CONSTS_VH
`define HWWD_CONSTS_VH

// Register indices and byte addresses
`define HWWD_IDX_RESTART     12'h0A6
`define HWWD_IDX_PERIOD      12'h0A7
`define HWWD_IDX_CONFIG      12'h0A8
`define HWWD_IDX_STATUS      12'h0A9
`define HWWD_IDX_PRESCALE    12'h0AA
`define HWWD_ADDR_W          12
`define HWWD_DATA_W          32
`define HWWD_ADDR_RESTART    (`HWWD_IDX_RESTART << 2)
`define HWWD_ADDR_PERIOD     (`HWWD_IDX_PERIOD << 2)
`define HWWD_ADDR_CONFIG     (`HWWD_IDX_CONFIG << 2)
`define HWWD_ADDR_STATUS     (`HWWD_IDX_STATUS << 2)
`define HWWD_ADDR_PRESCALE   (`HWWD_IDX_PRESCALE << 2)

// Restart key bytes
`define HWWD_KEY_FIRST       8'h1E
`define HWWD_KEY_SECOND      8'hE1

// Period register: timeout select field
`define HWWD_TOSEL_W         3
`define HWWD_TOSEL_MSB       2
`define HWWD_TOSEL_LSB       0
`define HWWD_TOSEL_RST       3'h0

// Config register: clock selection bits
`define HWWD_CFG_HALVE_BIT   0
`define HWWD_CFG_X2_BIT      1

// Status register fields
`define HWWD_ST_EN_BIT       0
`define HWWD_ST_ARMED_BIT    1
`define HWWD_ST_RSTOUT_BIT   2
`define HWWD_ST_CNT_LSB      8
`define HWWD_ST_CNT_MSB      14

// Counter structure
`define HWWD_PRE_W           14
`define HWWD_CNT_W           7
`define HWWD_PRE_MAX         14'h3FFF
// Last prescaler step before the wrap, one step short of a full pass
`define HWWD_PRE_TERM        14'h3FFE
`define HWWD_PHASE_W         3
`define HWWD_PHASE_LAST      3'h5

// Reset pulse: 96 oscillator periods; the oscillator is clk
`define HWWD_PULSE_PERIODS   96
`define HWWD_PULSE_W         7
`define HWWD_PULSE_LOAD      7'h60

`endif

// *** hwwd_watchdog.v ***
// Hardware watchdog timer with an APB register slave.
// Assumes clk is the oscillator clock; power mode flags are synchronous.
//
// Overview of operation
// - 14-bit prescaler on watchdog clock; its carry steps a 7-bit counter.
// - Chip reset clears the count and leaves the watchdog disabled.
// - Writing 1Eh then E1h to restart clears the count and enables.
// - Once enabled, only chip reset can disable the watchdog.
// - Overflow while enabled drives reset pin high 96 oscillator periods.
// - Halving bit set or standard mode: clock is oscillator/2, else oscillator.
// - Timeout is 6*(2^14*2^sel - 1) watchdog clocks.
// - Timeout select is period bits 2:0, reset 000, doubling per code.
// - Watchdog keeps counting in idle mode.
// - In power-down the count is held unchanged.
// - Leaving power-down by interrupt resumes from the held count.
// - Leaving power-down by reset clears and disables the watchdog.
// - Restart register is 8-bit write-only at index A6h.
//
// The APB slave port was left to the implementer.

`include "hwwd_consts.vh"

module hwwd_watchdog (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Chip power state
    input  wire        idle_mode,
    input  wire        power_down,
    // Chip reset request
    output reg         wd_reset_out
);

    localparam SEQ_IDLE  = 2'b01;
    localparam SEQ_ARMED = 2'b10;

    reg  [1:0]                  seq_state;
    reg                         wd_enabled;
    reg  [`HWWD_TOSEL_W-1:0]    timeout_select;
    reg                         wd_clock_halving_select;
    reg                         double_speed_mode;
    reg                         osc_half;
    reg  [`HWWD_PHASE_W-1:0]    phase;
    reg  [`HWWD_PRE_W-1:0]      prescaler;
    reg  [`HWWD_CNT_W-1:0]      counter;
    reg  [`HWWD_PULSE_W-1:0]    pulse_left;
    reg  [`HWWD_PHASE_W-1:0]    next_phase;
    reg  [`HWWD_PRE_W-1:0]      next_prescaler;
    reg  [`HWWD_CNT_W-1:0]      next_counter;
    reg  [`HWWD_PULSE_W-1:0]    next_pulse_left;
    reg                         next_reset_out;
    reg  [`HWWD_DATA_W-1:0]     next_prdata;
    reg                         next_pslverr;

    wire                        wr_access;
    wire                        setup;
    wire                        wr_restart;
    wire                        wr_period;
    wire                        wr_config;
    wire                        restart_ok;
    wire                        wd_tick;
    wire                        step_pre;
    wire                        carry;
    wire [`HWWD_CNT_W-1:0]      cnt_mask;
    wire                        overflow;
    wire                        clear_count;
    wire                        sel_restart;
    wire                        sel_period;
    wire                        sel_config;
    wire                        sel_status;
    wire                        sel_prescale;

    genvar                      gi;

    // APB decode: setup cycle and completing write access
    assign setup      = psel & ~penable;
    assign wr_access  = psel & penable & pready & pwrite;
    assign sel_restart  = (paddr == `HWWD_ADDR_RESTART);
    assign sel_period   = (paddr == `HWWD_ADDR_PERIOD);
    assign sel_config   = (paddr == `HWWD_ADDR_CONFIG);
    assign sel_status   = (paddr == `HWWD_ADDR_STATUS);
    assign sel_prescale = (paddr == `HWWD_ADDR_PRESCALE);
    assign wr_restart = wr_access & sel_restart;
    assign wr_period  = wr_access & sel_period;
    assign wr_config  = wr_access & sel_config;

    assign restart_ok = wr_restart & (seq_state == SEQ_ARMED)
                        & (pwdata[7:0] == `HWWD_KEY_SECOND);

    // key detector, any other restart write disarms
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seq_state <= SEQ_IDLE;
        end else if (wr_restart) begin
            case (seq_state)
                SEQ_IDLE: begin
                    if (pwdata[7:0] == `HWWD_KEY_FIRST) begin
                        seq_state <= SEQ_ARMED;
                    end
                end
                SEQ_ARMED: begin
                    if (pwdata[7:0] == `HWWD_KEY_FIRST) begin
                        seq_state <= SEQ_ARMED;
                    end else begin
                        seq_state <= SEQ_IDLE;
                    end
                end
                default: begin
                    seq_state <= SEQ_IDLE;
                end
            endcase
        end
    end

    // no write path clears the enable
    // a reset wake goes through rstn as well
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wd_enabled <= 1'b0;
        end else if (restart_ok) begin
            wd_enabled <= 1'b1;
        end
    end

    // timeout select field, upper bits not stored
    // bits 7:3 dropped, so stray ones do no harm
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            timeout_select <= `HWWD_TOSEL_RST;
        end else if (wr_period) begin
            timeout_select <= pwdata[`HWWD_TOSEL_MSB:`HWWD_TOSEL_LSB];
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wd_clock_halving_select <= 1'b0;
            double_speed_mode       <= 1'b0;
        end else if (wr_config) begin
            wd_clock_halving_select <= pwdata[`HWWD_CFG_HALVE_BIT];
            double_speed_mode       <= pwdata[`HWWD_CFG_X2_BIT];
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            osc_half <= 1'b0;
        end else if (!power_down) begin
            osc_half <= ~osc_half;
        end
    end

    // divide by two unless double speed without halving
    assign wd_tick = ~power_down
                     & ((~wd_clock_halving_select & double_speed_mode)
                        | osc_half);

    // six watchdog clocks per prescaler step
    assign step_pre = wd_tick & wd_enabled & (phase == `HWWD_PHASE_LAST);

    // idle_mode deliberately plays no part in counting
    always @* begin
        next_phase = phase;
        if (clear_count) begin
            next_phase = {`HWWD_PHASE_W{1'b0}};
        end else if (wd_tick & wd_enabled) begin
            if (phase == `HWWD_PHASE_LAST) begin
                next_phase = {`HWWD_PHASE_W{1'b0}};
            end else begin
                next_phase = phase + 1'b1;
            end
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase <= {`HWWD_PHASE_W{1'b0}};
        end else begin
            phase <= next_phase;
        end
    end

    // mask of counter bits used by the selected timeout
    generate
        for (gi = 0; gi < `HWWD_CNT_W; gi = gi + 1) begin : g_mask
            assign cnt_mask[gi] = (timeout_select > gi);
        end
    endgenerate

    assign carry    = step_pre & (prescaler == `HWWD_PRE_MAX);
    // overflow one step before the wrap, so the span ends at
    // six clocks times a full pass minus one
    assign overflow = step_pre & (prescaler == `HWWD_PRE_TERM)
                      & ((counter & cnt_mask) == cnt_mask);

    // Overflow also restarts the count so one timeout gives one pulse
    assign clear_count = restart_ok | overflow;

    // prescaler with carry into the counter
    // hold and resume, nothing is cleared on wake
    always @* begin
        next_prescaler = prescaler;
        next_counter   = counter;
        if (clear_count) begin
            next_prescaler = {`HWWD_PRE_W{1'b0}};
            next_counter   = {`HWWD_CNT_W{1'b0}};
        end else if (step_pre) begin
            next_prescaler = prescaler + 1'b1;
            if (carry) begin
                next_counter = counter + 1'b1;
            end
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prescaler <= {`HWWD_PRE_W{1'b0}};
            counter   <= {`HWWD_CNT_W{1'b0}};
        end else begin
            prescaler <= next_prescaler;
            counter   <= next_counter;
        end
    end

    always @* begin
        next_pulse_left = pulse_left;
        next_reset_out  = wd_reset_out;
        if (overflow) begin
            next_pulse_left = `HWWD_PULSE_LOAD - 1'b1;
            next_reset_out  = 1'b1;
        end else if (pulse_left != {`HWWD_PULSE_W{1'b0}}) begin
            next_pulse_left = pulse_left - 1'b1;
        end else begin
            next_reset_out  = 1'b0;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_left   <= {`HWWD_PULSE_W{1'b0}};
            wd_reset_out <= 1'b0;
        end else begin
            pulse_left   <= next_pulse_left;
            wd_reset_out <= next_reset_out;
        end
    end

    // Read mux; reserved bits read as zero
    always @* begin
        next_prdata  = {`HWWD_DATA_W{1'b0}};
        next_pslverr = 1'b0;
        if (sel_restart) begin
            // restart is write-only, reads give zero
            next_prdata = {`HWWD_DATA_W{1'b0}};
        end else if (sel_period) begin
            next_prdata[`HWWD_TOSEL_MSB:`HWWD_TOSEL_LSB] = timeout_select;
        end else if (sel_config) begin
            next_prdata[`HWWD_CFG_HALVE_BIT] = wd_clock_halving_select;
            next_prdata[`HWWD_CFG_X2_BIT]    = double_speed_mode;
        end else if (sel_status) begin
            next_prdata[`HWWD_ST_EN_BIT]     = wd_enabled;
            next_prdata[`HWWD_ST_ARMED_BIT]  = (seq_state == SEQ_ARMED);
            next_prdata[`HWWD_ST_RSTOUT_BIT] = wd_reset_out;
            next_prdata[`HWWD_ST_CNT_MSB:`HWWD_ST_CNT_LSB] = counter;
        end else if (sel_prescale) begin
            next_prdata[`HWWD_PRE_W-1:0] = prescaler;
        end else begin
            next_pslverr = 1'b1;
        end
    end

    // APB answer prepared in setup, so access ends after one cycle
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= {`HWWD_DATA_W{1'b0}};
        end else if (setup) begin
            pready  <= 1'b1;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // hwwd_watchdog

// *** hwwd_watchdog_sva.sv ***
// Checker for the watchdog: APB answer timing and the reset pulse.
// Assumes it is bound to hwwd_watchdog and sees only its ports.
`include "hwwd_consts.vh"

module hwwd_checker (
    // Clock and reset
    input wire        clk,
    input wire        rstn,
    // APB slave
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Chip reset request
    input wire        wd_reset_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire      mapped = paddr >= `HWWD_ADDR_RESTART &&
        paddr <= `HWWD_ADDR_PRESCALE && paddr[1:0] == 2'h0;
    // Length of the current reset pulse, in clk cycles
    logic [7:0] run;
    always @(posedge clk or negedge rstn)
        if (!rstn) run <= 8'h00;
        else run <= wd_reset_out ? run + 8'h01 : 8'h00;

    property p_ans; psel && !penable |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer after setup");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("pready longer than one cycle");
    property p_cause; $rose(pready) |-> $past(psel && !penable); endproperty
    a_cause: assert property (p_cause) else $error("pready without setup");
    property p_err; pslverr |-> pready && !mapped; endproperty
    a_err: assert property (p_err) else $error("pslverr on mapped address");
    property p_map; pready && !mapped |-> pslverr && prdata == 0; endproperty
    a_map: assert property (p_map) else $error("unmapped access not refused");
    property p_wo;
        pready && !pwrite && paddr == `HWWD_ADDR_RESTART |-> prdata == 0;
    endproperty
    a_wo: assert property (p_wo) else $error("restart read not zero");
    property p_rsv;
        pready && !pwrite && paddr == `HWWD_ADDR_PERIOD |-> prdata[31:3] == 0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("period upper bits set");
    property p_pulse; $fell(wd_reset_out) |-> run == 8'h60; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse not 96");
    property p_cap; run <= 8'h60; endproperty
    a_cap: assert property (p_cap) else $error("pulse over 96");
    c_pulse: cover property ($fell(wd_reset_out));
    c_err: cover property (pslverr);
    c_rd: cover property (pready && !pwrite);
endmodule // hwwd_checker

bind hwwd_watchdog hwwd_checker u_chk (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wd_reset_out(wd_reset_out));

// *** hardware_watchdog_timer_tb_top.sv ***
// Self-checking bench for the watchdog, driven over APB.
// Assumes the checker file is compiled first and binds itself.
`include "hwwd_consts.vh"

module hardware_watchdog_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        idle_mode = 0, power_down = 0, pready, pslverr, err;
    logic        wd_reset_out;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    int          mismatches = 0, num_checks = 0, n, a, a0, a2, a3;

    hwwd_watchdog uut (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .idle_mode(idle_mode), .power_down(power_down),
        .wd_reset_out(wd_reset_out));

    initial forever #2.5 clk = ~clk;

    task tally_and_finish;
        if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task chk(string nm, logic [31:0] e, s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Request held until pready is sampled high
    task xfer(logic w, logic [11:0] ad, logic [31:0] d);
        n = 0;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask

    task rc(logic [11:0] ad, logic [31:0] m, e, string nm);
        xfer(0, ad, 0);
        chk(nm, e, rd & m);
    endtask

    task arm(logic [7:0] mid);
        xfer(1, `HWWD_ADDR_RESTART, 8'h1E);
        xfer(1, `HWWD_ADDR_RESTART, mid);
        xfer(1, `HWWD_ADDR_RESTART, 8'hE1);
    endtask

    // Prescaler advance over a fixed span, wrap-safe
    task rate(logic [31:0] c, output int d);
        xfer(1, `HWWD_ADDR_CONFIG, c);
        xfer(0, `HWWD_ADDR_PRESCALE, 0);
        a = rd;
        repeat (1200) @(posedge clk);
        xfer(0, `HWWD_ADDR_PRESCALE, 0);
        d = (rd - a) & 32'h3FFF;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        rc(`HWWD_ADDR_STATUS, '1, 0, "status");
        rc(`HWWD_ADDR_PERIOD, '1, 0, "period");
        xfer(0, 12'h000, 0);
        chk("slverr", 1, err);
        xfer(1, `HWWD_ADDR_PERIOD, 7);
        rc(`HWWD_ADDR_PERIOD, '1, 7, "period");
        xfer(1, `HWWD_ADDR_PERIOD, 0);
        arm(8'h55);
        rc(`HWWD_ADDR_STATUS, 1, 0, "enable");
        arm(8'h1E);
        rc(`HWWD_ADDR_STATUS, 1, 1, "enable");
        rc(`HWWD_ADDR_RESTART, '1, 0, "restart");
        xfer(1, `HWWD_ADDR_RESTART, 0);
        xfer(1, `HWWD_ADDR_CONFIG, 0);
        rc(`HWWD_ADDR_STATUS, 1, 1, "enable");
        rate(0, a0);
        rate(2, a2);
        rate(3, a3);
        chk("x2 rate", 1, a2 > 2 * a0 - 4 && a2 < 2 * a0 + 4);
        chk("halved", 1, a3 > a0 - 2 && a3 < a0 + 2);
        arm(8'h1E);
        power_down <= 1;
        @(posedge clk);
        xfer(0, `HWWD_ADDR_PRESCALE, 0);
        a = rd;
        repeat (100) @(posedge clk);
        rc(`HWWD_ADDR_PRESCALE, '1, a, "freeze");
        idle_mode <= 1;
        power_down <= 0;
        repeat (100) @(posedge clk);
        xfer(0, `HWWD_ADDR_PRESCALE, 0);
        n = (rd - a) & 32'h3FFF;
        chk("resume", 1, n > 0 && n < 120);
        arm(8'h1E);
        power_down <= 1;
        rstn <= 0;
        repeat (5) @(posedge clk);
        rstn <= 1;
        power_down <= 0;
        rc(`HWWD_ADDR_STATUS, '1, 0, "status");
        xfer(1, `HWWD_ADDR_CONFIG, 2);
        arm(8'h1E);
        n = 0;
        while (wd_reset_out !== 1'b1 && n < 100000) begin
            @(posedge clk);
            n++;
        end
        chk("timeout", 1, n > 98288 && n < 98310);
        n = 0;
        while (wd_reset_out === 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk("pulse", 96, n);
        rc(`HWWD_ADDR_STATUS, 1, 1, "enable");
        tally_and_finish;
    end

    // Whole run is near 102300 cycles
    initial begin
        repeat (120000) @(posedge clk);
        mismatches++;
        tally_and_finish;
    end
endmodule // hardware_watchdog_timer_tb_top
